// File: hdl/aadse_decode.sv
// opcode and operand field decoder for the execution block
`timescale 1ns/10ps
module aadse_decode
    import aadse_pkg::*;
(
    input  wire logic [INSTR_W-1:0] instr_i,     // instruction word
    output logic                    is_and_o,    // and accumulator with file
    output logic                    is_dec_o,    // decrement skip on zero
    output logic                    to_file_o,   // result goes to file register
    output logic [FADDR_W-1:0]      faddr_o      // file register address
);

    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    logic [OPC_W-1:0] opc;

    // split the word into opcode, destination and address
    always_comb begin
        opc       = instr_i[OPC_HI:OPC_LO];
        is_and_o  = (opc == OPC_AND_ACCUMULATOR_WITH_FILE);
        is_dec_o  = (opc == OPC_DECREMENT_SKIP_ON_ZERO);
        to_file_o = (instr_i[DEST_BIT] == DEST_FILE);
        faddr_o   = instr_i[FADDR_HI:FADDR_LO];
    end

endmodule : aadse_decode

// File: hdl/aadse_exec.sv
// execution unit for and-accumulator-with-file and decrement-skip-on-zero
// What this block does
// - opcode 05 ands accumulator with file register, updates zero flag only, one cycle
// - destination bit 0 writes accumulator, 1 writes back the file register
// - opcode 0B writes file register minus one to destination, no flag changes
// - zero decrement result discards the already fetched next instruction
// - discarded slot runs as no-operation, so one cycle or two when skipping
`timescale 1ns/10ps
module aadse_exec
    import aadse_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF                  // data path width
)(
    input  wire logic               ref_clk_i,         // instruction clock
    input  wire logic               rst_i,             // synchronous reset, high
    input  wire logic               instr_valid_i,     // instruction presented
    input  wire logic [INSTR_W-1:0] instr_i,           // instruction word
    input  wire logic [DATA_W-1:0]  accum_i,           // current accumulator
    input  wire logic [DATA_W-1:0]  file_rdata_i,      // file data at file_raddr_o
    output logic [FADDR_W-1:0]      file_raddr_o,      // file read address
    output logic                    accum_we_o,        // accumulator write pulse
    output logic [DATA_W-1:0]       accum_wdata_o,     // accumulator write data
    output logic                    file_we_o,         // file write pulse
    output logic [FADDR_W-1:0]      file_waddr_o,      // file write address
    output logic [DATA_W-1:0]       file_wdata_o,      // file write data
    output logic                    zero_we_o,         // zero flag write pulse
    output logic                    zero_o,            // zero flag value
    output logic                    discard_o,         // next instruction is dropped
    output logic                    unsupported_o      // other opcode, ignored
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (DATA_W != DATA_W_DEF) begin : g_width_chk
        $error("aadse_exec: DATA_W must be 8");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        aadse_state_t        state;
        logic                accum_we;
        logic [DATA_W-1:0]   accum_wdata;
        logic                file_we;
        logic [FADDR_W-1:0]  file_waddr;
        logic [DATA_W-1:0]   file_wdata;
        logic                zero_we;
        logic                zero_val;
        logic                unsup;
    } aadse_regs_t;

    aadse_regs_t s;
    aadse_regs_t next_s;

    logic               is_and;
    logic               is_dec;
    logic               to_file;
    logic [FADDR_W-1:0] faddr;
    logic               exec;
    logic [DATA_W-1:0]  accum_eff;
    logic [DATA_W-1:0]  file_eff;
    logic [DATA_W-1:0]  and_res;
    logic [DATA_W-1:0]  dec_res;
    logic [DATA_W-1:0]  result;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    aadse_decode u_decode (
        .instr_i   (instr_i),
        .is_and_o  (is_and),
        .is_dec_o  (is_dec),
        .to_file_o (to_file),
        .faddr_o   (faddr)
    );

    // ------------------------------------------------------------
    // operands and results
    // ------------------------------------------------------------
    // forward last cycle's writes, the outside commits them only now
    always_comb begin
        exec      = instr_valid_i && (s.state == AADSE_EXEC);
        accum_eff = s.accum_we ? s.accum_wdata : accum_i;
        file_eff  = (s.file_we && (s.file_waddr == faddr)) ? s.file_wdata : file_rdata_i;
        and_res   = accum_eff & file_eff;
        dec_res   = file_eff - DEC_STEP;
        result    = is_and ? and_res : dec_res;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // one execution per valid cycle, dropped slot when discarding
    always_comb begin
        next_s          = s;
        next_s.accum_we = 1'b0;
        next_s.file_we  = 1'b0;
        next_s.zero_we  = 1'b0;
        next_s.unsup    = 1'b0;
        case (s.state)
            AADSE_EXEC: begin
                if (exec && (is_and || is_dec)) begin
                    if (to_file) begin
                        next_s.file_we    = 1'b1;
                        next_s.file_waddr = faddr;
                        next_s.file_wdata = result;
                    end else begin
                        next_s.accum_we    = 1'b1;
                        next_s.accum_wdata = result;
                    end
                end else if (exec) begin
                    next_s.unsup = 1'b1;
                end
                if (exec && is_and) begin
                    next_s.zero_we  = 1'b1;
                    next_s.zero_val = (and_res == ZERO_VAL);
                end
                if (exec && is_dec && (dec_res == ZERO_VAL)) begin
                    next_s.state = AADSE_DISCARD;
                end
            end
            AADSE_DISCARD: begin
                if (instr_valid_i) begin
                    next_s.state = AADSE_EXEC;
                end
            end
            default: begin
                next_s.state = AADSE_EXEC;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // state register with synchronous reset
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s.state       <= AADSE_EXEC;
            s.accum_we    <= 1'b0;
            s.accum_wdata <= DATA_RST;
            s.file_we     <= 1'b0;
            s.file_waddr  <= FADDR_RST;
            s.file_wdata  <= DATA_RST;
            s.zero_we     <= 1'b0;
            s.zero_val    <= 1'b0;
            s.unsup       <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // registered writes, combinational read address
    always_comb begin
        file_raddr_o  = faddr;
        accum_we_o    = s.accum_we;
        accum_wdata_o = s.accum_wdata;
        file_we_o     = s.file_we;
        file_waddr_o  = s.file_waddr;
        file_wdata_o  = s.file_wdata;
        zero_we_o     = s.zero_we;
        zero_o        = s.zero_val;
        discard_o     = (s.state == AADSE_DISCARD);
        unsupported_o = s.unsup;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    logic exec_and;
    logic exec_dec;

    // qualified execution strobes
    always_comb begin
        exec_and = exec && is_and;
        exec_dec = exec && is_dec;
    end

    and_result_a : assert property (exec_and |=>
        zero_we_o && (zero_o == ($past(and_res) == ZERO_VAL)) && !discard_o &&
        ((accum_we_o && accum_wdata_o == $past(accum_eff & file_eff)) ||
         (file_we_o && file_wdata_o == $past(accum_eff & file_eff))))
        else $error("and result or zero flag wrong");

    dest_route_a : assert property ((exec_and || exec_dec) |=>
        ($past(to_file) ? (file_we_o && !accum_we_o && file_waddr_o == $past(faddr))
                        : (accum_we_o && !file_we_o)))
        else $error("result routed to wrong destination");

    dec_noflag_a : assert property (exec_dec |=>
        !zero_we_o && ((accum_we_o ? accum_wdata_o : file_wdata_o) == $past(file_eff) - DEC_STEP))
        else $error("decrement wrong or flag touched");

    skip_zero_a : assert property (exec_dec |=>
        (discard_o == ($past(file_eff) == DEC_STEP)))
        else $error("skip decision wrong");

    nop_slot_a : assert property (discard_o && instr_valid_i |=>
        !accum_we_o && !file_we_o && !zero_we_o && !unsupported_o && !discard_o)
        else $error("discarded instruction had an effect");

    one_cycle_a : assert property (exec_dec && (file_eff != DEC_STEP) |=> !discard_o)
        else $error("non-skip decrement stalled");

    and_cov_c  : cover property (exec_and && to_file);
    skip_cov_c : cover property (exec_dec ##1 discard_o && instr_valid_i ##1 exec);
    fwd_cov_c  : cover property (exec_dec && to_file ##1 exec_dec && (faddr == file_waddr_o) && file_we_o);

endmodule : aadse_exec

// File: include/aadse_pkg.sv
// shared constants and types for the and / decrement-skip execution block
package aadse_pkg;

    // ------------------------------------------------------------
    // instruction word layout
    // ------------------------------------------------------------
    localparam int          INSTR_W    = 14;
    localparam int          OPC_HI     = 13;
    localparam int          OPC_LO     = 8;
    localparam int          OPC_W      = OPC_HI - OPC_LO + 1;
    localparam int          DEST_BIT   = 7;
    localparam int          FADDR_HI   = 6;
    localparam int          FADDR_LO   = 0;
    localparam int          FADDR_W    = FADDR_HI - FADDR_LO + 1;

    // ------------------------------------------------------------
    // opcodes and destination codes
    // ------------------------------------------------------------
    localparam logic [5:0]  OPC_AND_ACCUMULATOR_WITH_FILE = 6'h05;
    localparam logic [5:0]  OPC_DECREMENT_SKIP_ON_ZERO    = 6'h0B;
    localparam logic        DEST_ACCUM = 1'h0;
    localparam logic        DEST_FILE  = 1'h1;

    // ------------------------------------------------------------
    // data constants and reset values
    // ------------------------------------------------------------
    localparam int          DATA_W_DEF = 8;
    localparam logic [7:0]  DEC_STEP   = 8'h01;
    localparam logic [7:0]  ZERO_VAL   = 8'h00;
    localparam logic [7:0]  DATA_RST   = 8'h00;
    localparam logic [6:0]  FADDR_RST  = 7'h00;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        AADSE_EXEC,
        AADSE_DISCARD
    } aadse_state_t;

endpackage : aadse_pkg

// File: sim/tb_and_and_decrement_skip_exec.sv
// self-checking testbench for the and / decrement-skip execution block
`timescale 1ns/10ps
module tb_and_and_decrement_skip_exec;
    import aadse_pkg::*;

    // ------------------------------------------------------------
    // stimulus, outputs and a small register file around the block
    // ------------------------------------------------------------
    logic                 ref_clk_i     = 1'h0;
    logic                 rst_i         = 1'h1;
    logic                 instr_valid_i = 1'h0;
    logic [INSTR_W-1:0]   instr_i       = 14'h0000;
    logic [7:0]           acc           = 8'h00;
    logic [7:0]           mem [0:127];
    logic [FADDR_W-1:0]   file_raddr_o, file_waddr_o;
    logic [7:0]           accum_wdata_o, file_wdata_o;
    logic                 accum_we_o, file_we_o, zero_we_o, zero_o, discard_o, unsupported_o;
    int                   errors        = 0;
    int                   check_count   = 0;

    aadse_exec #(.DATA_W(8)) uut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .accum_i(acc), .file_rdata_i(mem[file_raddr_o]), .file_raddr_o(file_raddr_o),
        .accum_we_o(accum_we_o), .accum_wdata_o(accum_wdata_o), .file_we_o(file_we_o),
        .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o), .zero_we_o(zero_we_o),
        .zero_o(zero_o), .discard_o(discard_o), .unsupported_o(unsupported_o));

    // 10 MHz clock
    always #50 ref_clk_i = ~ref_clk_i;

    // commit write pulses at the edge that ends them
    always @(posedge ref_clk_i) begin
        if (accum_we_o === 1'h1) acc <= accum_wdata_o;
        if (file_we_o === 1'h1) mem[file_waddr_o] <= file_wdata_o;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [13:0] word(input logic [5:0] opc, input logic d, input logic [6:0] f);
        return {opc, d, f};
    endfunction : word

    // present one word, return in its answer cycle
    task automatic drive(input logic [13:0] w);
        instr_valid_i = 1'h1;
        instr_i = w;
        @(negedge ref_clk_i);
    endtask : drive

    task automatic idle();
        instr_valid_i = 1'h0;
        @(negedge ref_clk_i);
    endtask : idle

    task automatic expect_out(input logic aw, fw, zw, z, dc, un, input logic [7:0] d, input logic [6:0] a);
        check("accum_we", accum_we_o, aw);
        check("file_we", file_we_o, fw);
        check("zero_we", zero_we_o, zw);
        if (zw) check("zero", zero_o, z);
        check("discard", discard_o, dc);
        check("unsupported", unsupported_o, un);
        if (aw) check("accum_wdata", accum_wdata_o, d);
        if (fw) check("file_wdata", file_wdata_o, d);
        if (fw) check("file_waddr", {1'h0, file_waddr_o}, {1'h0, a});
    endtask : expect_out

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_and();
        acc = 8'h17;
        mem[4] = 8'hC2;
        drive(word(OPC_AND_ACCUMULATOR_WITH_FILE, DEST_FILE, 7'h04));
        expect_out(0, 1, 1, 0, 0, 0, 8'h17 & 8'hC2, 7'h04);
        drive(word(OPC_AND_ACCUMULATOR_WITH_FILE, DEST_ACCUM, 7'h04));
        expect_out(1, 0, 1, 0, 0, 0, 8'h17 & 8'h02, 7'h00);
        idle();
        acc = 8'hF0;
        mem[127] = 8'h0F;
        drive(word(OPC_AND_ACCUMULATOR_WITH_FILE, DEST_ACCUM, 7'h7F));
        expect_out(1, 0, 1, 1, 0, 0, 8'h00, 7'h00);
        idle();
        $display("test and done");
    endtask : t_and

    task automatic t_dec();
        mem[5] = 8'h05;
        mem[16] = 8'h00;
        drive(word(OPC_DECREMENT_SKIP_ON_ZERO, DEST_ACCUM, 7'h05));
        expect_out(1, 0, 0, 0, 0, 0, 8'h04, 7'h00);
        // back to back: accumulator still stale outside, block must forward
        drive(word(OPC_AND_ACCUMULATOR_WITH_FILE, DEST_ACCUM, 7'h05));
        expect_out(1, 0, 1, 0, 0, 0, 8'h04, 7'h00);
        drive(word(OPC_DECREMENT_SKIP_ON_ZERO, DEST_FILE, 7'h10));
        expect_out(0, 1, 0, 0, 0, 0, 8'hFF, 7'h10);
        idle();
        $display("test decrement done");
    endtask : t_dec

    task automatic t_skip();
        mem[9] = 8'h01;
        mem[32] = 8'h01;
        drive(word(OPC_DECREMENT_SKIP_ON_ZERO, DEST_FILE, 7'h09));
        expect_out(0, 1, 0, 0, 1, 0, 8'h00, 7'h09);
        drive(word(OPC_AND_ACCUMULATOR_WITH_FILE, DEST_FILE, 7'h09));
        expect_out(0, 0, 0, 0, 0, 0, 8'h00, 7'h00);
        acc = 8'h3C;
        drive(word(OPC_AND_ACCUMULATOR_WITH_FILE, DEST_ACCUM, 7'h09));
        expect_out(1, 0, 1, 1, 0, 0, 8'h00, 7'h00);
        idle();
        drive(word(OPC_DECREMENT_SKIP_ON_ZERO, DEST_ACCUM, 7'h20));
        expect_out(1, 0, 0, 0, 1, 0, 8'h00, 7'h00);
        idle();
        idle();
        check("discard_stall", discard_o, 1'h1);
        drive(word(6'h07, DEST_FILE, 7'h09));
        expect_out(0, 0, 0, 0, 0, 0, 8'h00, 7'h00);
        idle();
        $display("test skip done");
    endtask : t_skip

    // reset in the middle of a pending discard clears it
    task automatic t_reset();
        mem[40] = 8'h01;
        drive(word(OPC_DECREMENT_SKIP_ON_ZERO, DEST_ACCUM, 7'h28));
        expect_out(1, 0, 0, 0, 1, 0, 8'h00, 7'h00);
        instr_valid_i = 1'h0;
        rst_i = 1'h1;
        @(negedge ref_clk_i);
        expect_out(0, 0, 0, 0, 0, 0, 8'h00, 7'h00);
        rst_i = 1'h0;
        acc = 8'h81;
        drive(word(OPC_AND_ACCUMULATOR_WITH_FILE, DEST_ACCUM, 7'h28));
        expect_out(1, 0, 1, 0, 0, 0, 8'h01, 7'h00);
        idle();
        $display("test reset done");
    endtask : t_reset

    task automatic t_unsup();
        logic [5:0] opcs [3] = '{6'h07, 6'h00, 6'h3F};
        foreach (opcs[i]) begin
            drive(word(opcs[i], DEST_FILE, 7'h04));
            expect_out(0, 0, 0, 0, 0, 1, 8'h00, 7'h00);
            idle();
        end
        $display("test other opcodes done");
    endtask : t_unsup

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (6) @(negedge ref_clk_i);
        rst_i = 1'h0;
        expect_out(0, 0, 0, 0, 0, 0, 8'h00, 7'h00);
        t_and();
        t_dec();
        t_skip();
        t_reset();
        t_unsup();
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge ref_clk_i);
        errors++;
        $display("run took too long");
        give_verdict();
    end

endmodule : tb_and_and_decrement_skip_exec
